/* File: verilog/mrs_cfg.svh */
// Constants of the serial slave port: offsets, fields, resets, timing.
// Assumes a single 200 MHz system clock.
`ifndef MRS_CFG_SVH
`define MRS_CFG_SVH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define MRS_CLK_HZ 200000000
`define MRS_MS_PER_S 1000
`define MRS_TMO_UNIT_MS 100
`define MRS_GAP_BITS 38
`define MRS_BAUD0 4800
`define MRS_BAUD1 9600
`define MRS_BAUD2 19200
`define MRS_BAUD3 38400
`define MRS_BAUD4 57600
`define MRS_BAUD5 115200
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MRS_A_STATION 8'h00
`define MRS_A_BAUD 8'h04
`define MRS_A_FMT 8'h08
`define MRS_A_TMO 8'h0C
`define MRS_A_DLY 8'h10
`define MRS_A_PROTO 8'h14
`define MRS_A_STAT 8'h18
`define MRS_A_CLR 8'h1C
`define MRS_A_IEN 8'h20
`define MRS_A_STATE 8'h24
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define MRS_RST_STATION 8'h01
`define MRS_RST_BAUD 3'h1
`define MRS_RST_FMT 3'h0
`define MRS_RST_TMO 10'h000
`define MRS_RST_DLY 5'h02
`define MRS_PROTO_RTU 32'h00000000
`define MRS_BCAST_ADDR 8'h00
`define MRS_ADDR_MAX 32'h000000F7
`define MRS_CODE_MAX 32'h00000005
`define MRS_TMO_MAX 32'h00000258
`define MRS_DLY_MAX 32'h00000014
`define MRS_LEN_MIN 9'h004
`define MRS_LEN_MAX 9'h100
// ----------------------------------------
// Status bits and frame check
// ----------------------------------------
`define MRS_ST_FRAME 0
`define MRS_ST_BAD 1
`define MRS_ST_TMO 2
`define MRS_CRC_INIT 16'hFFFF
`define MRS_CRC_POLY 16'hA001
`endif

/* File: verilog/mrs_pkg.sv */
// Types shared by the serial slave port files.
// Assumes nothing beyond the compile order.
package mrs_pkg;
	typedef logic [7:0] mrs_byte_t;
	typedef enum logic [2:0] {
		MRS_RX_IDLE = 3'h0,
		MRS_RX_START = 3'h1,
		MRS_RX_DATA = 3'h2,
		MRS_RX_PAR = 3'h3,
		MRS_RX_STOP1 = 3'h4,
		MRS_RX_STOP2 = 3'h5
	} mrs_rx_e;
endpackage: mrs_pkg

/* File: verilog/mrs_uart_tx.sv */
// Character transmitter of the serial slave port.
// Assumes bit_div and format stay still while a character is sent.
`timescale 1ns/1ps
module mrs_uart_tx (
	input wire logic ref_clk, // System clock
	input wire logic rst, // Async reset
	input wire logic [15:0] bit_div, // Cycles per bit
	input wire logic par_en, // Parity bit present
	input wire logic par_odd, // Odd parity
	input wire logic two_stop, // Two stop bits
	input wire mrs_pkg::mrs_byte_t in_data, // Byte to send
	input wire logic in_valid, // Byte offered
	output logic in_ready, // Idle, byte taken
	output logic txd, // Serial out
	output logic busy // Character in flight
);
	import mrs_pkg::*;
	logic [11:0] sh_q;
	logic [3:0] left_q;
	logic [15:0] cnt_q;
	logic txd_q;
	// RL8 parity generation
	wire par_bit = (^in_data) ^ par_odd;
	// RL6 character framing
	wire [11:0] frm = par_en ? {2'h3, par_bit, in_data, 1'h0} : {3'h7, in_data, 1'h0};
	wire [3:0] nbits = 4'hA + {3'h0, par_en} + {3'h0, two_stop};
	wire tick = cnt_q == 16'h0000;
	assign in_ready = left_q == 4'h0;
	assign busy = !in_ready;
	assign txd = txd_q;
	// RL5 one bit per divider period
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			sh_q <= 12'hFFF;
			left_q <= 4'h0;
			cnt_q <= 16'h0000;
			txd_q <= 1'h1;
		end
		else if (in_valid && in_ready)
		begin
			txd_q <= frm[0];
			sh_q <= {1'h1, frm[11:1]};
			left_q <= nbits;
			cnt_q <= bit_div - 16'h0001;
		end
		else if (busy)
		begin
			cnt_q <= tick ? bit_div - 16'h0001 : cnt_q - 16'h0001;
			if (tick)
			begin
				left_q <= left_q - 4'h1;
				txd_q <= (left_q == 4'h1) ? 1'h1 : sh_q[0];
				sh_q <= {1'h1, sh_q[11:1]};
			end
		end
	end
endmodule: mrs_uart_tx

/* File: verilog/mrs_serial_port.sv */
// Modbus RTU serial slave port: receiver, frame check, timeout, reply gate.
// Assumes rxd synchronous to ref_clk and a register master that never waits.
// Behaviour
// RL1: Local station 1..247, reset 1; accept only frames for it or broadcast.
// RL2: Address zero is broadcast and always accepted.
// RL3: Integrator gives every slave a distinct address, at most 247 slaves.
// RL4: Baud code 0..5 selects 4800..115200 bit/s; code 1 after reset.
// RL5: Bits shift at exactly the selected baud rate; the divider is CLK_HZ/baud rounded down, so it is not exact at 200 MHz.
// RL6: Character: start, eight data, optional parity, one or two stops.
// RL7: Format code 0..5 selects parity and stop count; code 0 after reset.
// RL8: Parity bit is even or odd over data, generated and checked.
// RL9: Master and slaves share baud, format and protocol settings.
// RL10: Protocol selection defaults to Modbus RTU.
// RL11: Timeout interval runs from one valid frame, restarts on each.
// RL12: Interval beyond setting, 0.0 to 60.0 s, raises timeout fault.
// RL13: Setting zero, the reset value, disables timeout detection.
// RL14: Valid frame needs good function code, length and CRC.
// RL15: Reply waits 1..20 ms after a valid frame, default 2.
// RL16: Parity or stop bit error makes the whole frame invalid.
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`include "mrs_cfg.svh"
module mrs_serial_port #(
	parameter int CLK_HZ = `MRS_CLK_HZ // System clock rate
) (
	input wire logic ref_clk, // System clock
	input wire logic rst, // Async reset
	input wire logic [7:0] reg_addr, // Register byte address
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic reg_we, // Write strobe
	input wire logic reg_re, // Read strobe
	output logic [31:0] reg_rdata, // Read data, next cycle
	input wire logic rxd, // Serial in
	output logic txd, // Serial out
	output logic txd_oe, // Line driver enable
	output mrs_pkg::mrs_byte_t rx_byte, // Received byte
	output logic rx_byte_valid, // Received byte pulse
	output logic frame_valid, // Valid frame pulse
	output logic frame_bcast, // Valid broadcast pulse
	input wire mrs_pkg::mrs_byte_t tx_data, // Reply byte
	input wire logic tx_valid, // Reply byte offered
	input wire logic tx_last, // Last reply byte
	output logic tx_ready, // Reply byte taken
	output logic comm_fault, // Timeout fault level
	output logic irq // Interrupt level
);
	import mrs_pkg::*;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int MS_CYC = CLK_HZ / `MRS_MS_PER_S;
	// RL4 baud code map
	localparam logic [15:0] DIV [0:5] = '{
		16'(CLK_HZ / `MRS_BAUD0), 16'(CLK_HZ / `MRS_BAUD1),
		16'(CLK_HZ / `MRS_BAUD2), 16'(CLK_HZ / `MRS_BAUD3),
		16'(CLK_HZ / `MRS_BAUD4), 16'(CLK_HZ / `MRS_BAUD5)};
	function automatic logic [15:0] crc_step(input logic [15:0] c, input mrs_byte_t d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ `MRS_CRC_POLY) : (r >> 1);
		return r;
	endfunction: crc_step
	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic [7:0] station_q;
	logic [2:0] baud_q, fmt_q, ien_q, st_q;
	logic [9:0] tmo_q;
	logic [4:0] dly_q;
	wire wr_sta = reg_we && reg_addr == `MRS_A_STATION;
	wire wr_baud = reg_we && reg_addr == `MRS_A_BAUD;
	wire wr_fmt = reg_we && reg_addr == `MRS_A_FMT;
	wire wr_tmo = reg_we && reg_addr == `MRS_A_TMO;
	wire wr_dly = reg_we && reg_addr == `MRS_A_DLY;
	wire wr_clr = reg_we && reg_addr == `MRS_A_CLR;
	wire wr_ien = reg_we && reg_addr == `MRS_A_IEN;
	wire wd_nz = reg_wdata != 32'h00000000;
	// RL1 RL4 RL7 RL12 RL15 write limits
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			station_q <= `MRS_RST_STATION;
			baud_q <= `MRS_RST_BAUD;
			fmt_q <= `MRS_RST_FMT;
			tmo_q <= `MRS_RST_TMO;
			dly_q <= `MRS_RST_DLY;
			ien_q <= 3'h0;
		end
		else
		begin
			if (wr_sta && wd_nz && reg_wdata <= `MRS_ADDR_MAX)
				station_q <= reg_wdata[7:0];
			if (wr_baud && reg_wdata <= `MRS_CODE_MAX)
				baud_q <= reg_wdata[2:0];
			if (wr_fmt && reg_wdata <= `MRS_CODE_MAX)
				fmt_q <= reg_wdata[2:0];
			if (wr_tmo && reg_wdata <= `MRS_TMO_MAX)
				tmo_q <= reg_wdata[9:0];
			if (wr_dly && wd_nz && reg_wdata <= `MRS_DLY_MAX)
				dly_q <= reg_wdata[4:0];
			if (wr_ien)
				ien_q <= reg_wdata[2:0];
		end
	end
	// RL7 format decode
	wire par_en = fmt_q == 3'h1 || fmt_q == 3'h2 || fmt_q == 3'h4 || fmt_q == 3'h5;
	wire par_odd = fmt_q == 3'h2 || fmt_q == 3'h5;
	wire two_stop = fmt_q >= 3'h3;
	wire [15:0] bit_div = DIV[baud_q];
	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	mrs_rx_e rx_st_q, rx_st_d;
	logic [15:0] bcnt_q;
	logic [2:0] bitn_q;
	mrs_byte_t sh_q;
	logic perr_q;
	logic rxv_q, fv_q, fb_q;
	mrs_byte_t rxb_q;
	wire rx_busy = rx_st_q != MRS_RX_IDLE;
	wire bit_tick = rx_busy && bcnt_q == 16'h0000;
	wire start_det = !rx_busy && !rxd;
	wire in_stop = rx_st_q == MRS_RX_STOP1 || rx_st_q == MRS_RX_STOP2;
	wire char_done = bit_tick && in_stop && !(rx_st_q == MRS_RX_STOP1 && two_stop && rxd);
	// RL16 stop or parity failure
	wire char_bad = !rxd || perr_q;
	// RL5 mid-bit sampling at baud rate
	wire [15:0] bcnt_d = start_det ? {1'h0, bit_div[15:1]} : bit_tick ? bit_div - 16'h0001
		: rx_busy ? bcnt_q - 16'h0001 : bcnt_q;
	always_comb
	begin
		rx_st_d = rx_st_q;
		case (rx_st_q)
			MRS_RX_IDLE: if (!rxd) rx_st_d = MRS_RX_START;
			MRS_RX_START: if (bit_tick) rx_st_d = rxd ? MRS_RX_IDLE : MRS_RX_DATA;
			MRS_RX_DATA:
				if (bit_tick && bitn_q == 3'h7)
					rx_st_d = par_en ? MRS_RX_PAR : MRS_RX_STOP1;
			MRS_RX_PAR: if (bit_tick) rx_st_d = MRS_RX_STOP1;
			MRS_RX_STOP1:
				if (bit_tick)
					rx_st_d = (two_stop && rxd) ? MRS_RX_STOP2 : MRS_RX_IDLE;
			MRS_RX_STOP2: if (bit_tick) rx_st_d = MRS_RX_IDLE;
			default: rx_st_d = MRS_RX_IDLE;
		endcase
	end
	// RL6 data bits, RL8 parity check
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			rx_st_q <= MRS_RX_IDLE;
			bcnt_q <= 16'h0000;
			bitn_q <= 3'h0;
			sh_q <= 8'h00;
			perr_q <= 1'h0;
			rxv_q <= 1'h0;
			rxb_q <= 8'h00;
		end
		else
		begin
			rx_st_q <= rx_st_d;
			bcnt_q <= bcnt_d;
			rxv_q <= char_done && !char_bad;
			rxb_q <= sh_q;
			if (bit_tick && rx_st_q == MRS_RX_START)
			begin
				bitn_q <= 3'h0;
				perr_q <= 1'h0;
			end
			if (bit_tick && rx_st_q == MRS_RX_DATA)
			begin
				sh_q <= {rxd, sh_q[7:1]};
				bitn_q <= bitn_q + 3'h1;
			end
			if (bit_tick && rx_st_q == MRS_RX_PAR)
				perr_q <= rxd != ((^sh_q) ^ par_odd);
		end
	end
	// ----------------------------------------
	// Frame assembly and check
	// ----------------------------------------
	logic [8:0] len_q;
	mrs_byte_t faddr_q, ffc_q;
	logic [15:0] crc_q;
	logic ferr_q;
	logic [23:0] gap_q;
	wire [23:0] gap_lim = 24'(bit_div) * 24'(`MRS_GAP_BITS);
	wire frame_end = len_q != 9'h000 && gap_q == gap_lim;
	// RL1 RL2 address filter
	wire addr_ok = faddr_q == station_q || faddr_q == `MRS_BCAST_ADDR;
	// RL14 code, length and CRC
	wire body_ok = crc_q == 16'h0000 && len_q >= `MRS_LEN_MIN && len_q <= `MRS_LEN_MAX
		&& ffc_q != 8'h00 && !ffc_q[7];
	wire valid_now = frame_end && addr_ok && body_ok && !ferr_q;
	wire bad_now = frame_end && addr_ok && !valid_now;
	wire gap_hold = rx_busy || len_q == 9'h000 || frame_end;
	wire [23:0] gap_d = gap_hold ? 24'h000000 : gap_q + 24'h000001;
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			len_q <= 9'h000;
			faddr_q <= 8'h00;
			ffc_q <= 8'h00;
			crc_q <= `MRS_CRC_INIT;
			ferr_q <= 1'h0;
		end
		else if (char_done)
		begin
			len_q <= len_q + {8'h00, len_q != 9'h1FF};
			if (len_q == 9'h000)
				faddr_q <= sh_q;
			if (len_q == 9'h001)
				ffc_q <= sh_q;
			crc_q <= crc_step(crc_q, sh_q);
			// RL16 error poisons frame
			ferr_q <= ferr_q || char_bad;
		end
		else if (frame_end)
		begin
			len_q <= 9'h000;
			crc_q <= `MRS_CRC_INIT;
			ferr_q <= 1'h0;
		end
	end
	assign rx_byte = rxb_q;
	assign rx_byte_valid = rxv_q;
	assign frame_valid = fv_q;
	assign frame_bcast = fb_q;
	// ----------------------------------------
	// Timeout monitor
	// ----------------------------------------
	logic [17:0] mscnt_q;
	logic [16:0] tms_q;
	logic fault_q;
	wire ms_tick = mscnt_q == 18'(MS_CYC - 1);
	wire [16:0] tlim = 17'(tmo_q) * 17'(`MRS_TMO_UNIT_MS);
	wire over = tms_q > tlim;
	// RL12 fault beyond setting, RL13 zero disables
	wire fault_d = tmo_q != 10'h000 && over && !valid_now;
	// RL11 restart on valid frame
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			mscnt_q <= 18'h00000;
			tms_q <= 17'h00000;
			fault_q <= 1'h0;
			gap_q <= 24'h000000;
			fv_q <= 1'h0;
			fb_q <= 1'h0;
		end
		else
		begin
			mscnt_q <= ms_tick ? 18'h00000 : mscnt_q + 18'h00001;
			fault_q <= fault_d;
			gap_q <= gap_d;
			fv_q <= valid_now;
			fb_q <= valid_now && faddr_q == `MRS_BCAST_ADDR;
			if (valid_now)
				tms_q <= 17'h00000;
			else if (ms_tick && !over)
				tms_q <= tms_q + 17'h00001;
		end
	end
	assign comm_fault = fault_q;
	// ----------------------------------------
	// Reply delay and transmitter
	// ----------------------------------------
	logic [22:0] dcnt_q;
	logic rwait_q, ropen_q;
	logic tx_in_ready, tx_busy;
	wire [22:0] dly_cyc = 23'(dly_q) * 23'(MS_CYC);
	wire tx_take = tx_valid && tx_ready;
	// RL15 response delay
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			dcnt_q <= 23'h000000;
			rwait_q <= 1'h0;
			ropen_q <= 1'h0;
		end
		else if (valid_now && faddr_q != `MRS_BCAST_ADDR)
		begin
			dcnt_q <= dly_cyc - 23'h000001;
			rwait_q <= 1'h1;
			ropen_q <= 1'h0;
		end
		else if (rwait_q)
		begin
			dcnt_q <= dcnt_q - {22'h000000, dcnt_q != 23'h000000};
			rwait_q <= dcnt_q != 23'h000000;
			ropen_q <= dcnt_q == 23'h000000;
		end
		else if (tx_take && tx_last)
			ropen_q <= 1'h0;
	end
	assign tx_ready = ropen_q && tx_in_ready;
	assign txd_oe = tx_busy;
	mrs_uart_tx u_tx (.ref_clk(ref_clk), .rst(rst), .bit_div(bit_div), .par_en(par_en),
		.par_odd(par_odd), .two_stop(two_stop), .in_data(tx_data),
		.in_valid(tx_valid && ropen_q), .in_ready(tx_in_ready), .txd(txd), .busy(tx_busy));
	// ----------------------------------------
	// Interrupts and read-back
	// ----------------------------------------
	wire [2:0] ev = {fault_d && !fault_q, bad_now, valid_now};
	wire [2:0] st_d = (st_q & ~(wr_clr ? reg_wdata[2:0] : 3'h0)) | ev;
	assign irq = |(st_q & ien_q);
	// RL10 protocol fixed to RTU
	wire [31:0] rd_mux =
		reg_addr == `MRS_A_STATION ? {24'h000000, station_q} :
		reg_addr == `MRS_A_BAUD ? {29'h00000000, baud_q} :
		reg_addr == `MRS_A_FMT ? {29'h00000000, fmt_q} :
		reg_addr == `MRS_A_TMO ? {22'h000000, tmo_q} :
		reg_addr == `MRS_A_DLY ? {27'h0000000, dly_q} :
		reg_addr == `MRS_A_PROTO ? `MRS_PROTO_RTU :
		reg_addr == `MRS_A_STAT ? {29'h00000000, st_q} :
		reg_addr == `MRS_A_IEN ? {29'h00000000, ien_q} :
		reg_addr == `MRS_A_STATE ? {29'h00000000, fault_q, ropen_q, rx_busy} :
		32'h00000000;
	logic [31:0] rdata_q;
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= 3'h0;
			rdata_q <= 32'h00000000;
		end
		else
		begin
			st_q <= st_d;
			rdata_q <= reg_re ? rd_mux : 32'h00000000;
		end
	end
	assign reg_rdata = rdata_q;
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	AST_ADDR_FILTER: assert property (frame_valid // RL1
		|-> $past(faddr_q) == $past(station_q) || $past(faddr_q) == 8'h00)
		else $error("frame accepted for foreign station");
	AST_STATION_RANGE: assert property (station_q != 8'h00 && station_q <= 8'hF7) // RL1
		else $error("station address out of range");
	AST_BCAST: assert property (valid_now && faddr_q == 8'h00 |=> frame_bcast && frame_valid) // RL2
		else $error("broadcast frame not flagged");
	AST_BIT_TIME: assert property (bit_tick && rx_st_q == MRS_RX_DATA |=> bcnt_q == $past(bit_div) - 16'h0001) // RL5
		else $error("bit period differs from baud divisor");
	AST_BAD_CHAR: assert property (frame_end && ferr_q |=> !frame_valid) // RL16
		else $error("frame with character error accepted");
	AST_CRC: assert property (frame_end && crc_q != 16'h0000 |=> !frame_valid) // RL14
		else $error("frame with bad CRC accepted");
	AST_TMO_OFF: assert property (tmo_q == 10'h000 |=> !comm_fault) // RL13
		else $error("timeout fault while disabled");
	AST_TMO_RESTART: assert property (frame_valid |-> tms_q == 17'h00000 && !comm_fault) // RL11
		else $error("timeout count not restarted");
	AST_DELAY: assert property (valid_now && faddr_q != 8'h00 |=> !tx_ready [*2]) // RL15
		else $error("reply opened without delay");
	AST_TX_GATE: assert property (tx_ready |-> ropen_q && !rwait_q) // RL15
		else $error("reply taken before delay ran out");
	COV_FRAME: cover property (frame_valid && !frame_bcast);
	COV_BCAST: cover property (frame_bcast);
	COV_TMO: cover property ($rose(comm_fault));
	COV_REPLY: cover property (tx_ready && tx_valid && tx_last);
endmodule: mrs_serial_port

/* File: tb/mrs_master_model.sv */
// Master station model driving the slave's serial input.
// Assumes the bench sets div and fmt to match the slave's settings.
`timescale 1ns/1ps
module mrs_master_model (
	input wire logic ref_clk, // System clock
	output logic rxd, // Line toward slave
	input wire logic txd // Line from slave
);
	int div = 60;
	logic [2:0] fmt = 3'h0;
	int mrx_n = 0;
	logic [7:0] mrx_b = 8'h00;
	logic mrx_err = 1'b0;
	initial rxd = 1'b1;
	function automatic logic par_en();
		par_en = fmt != 3'h0 && fmt != 3'h3;
	endfunction: par_en
	function automatic logic par_of(input logic [7:0] b);
		par_of = ^b ^ (fmt == 3'h2 || fmt == 3'h5);
	endfunction: par_of
	task automatic bit_out(input logic v);
		rxd <= v;
		repeat (div) @(posedge ref_clk);
	endtask: bit_out
	task automatic send_char(input logic [7:0] b, input logic bad);
		@(posedge ref_clk);
		bit_out(1'b0);
		for (int i = 0; i < 8; i++)
			bit_out(b[i]);
		if (par_en())
			bit_out(par_of(b) ^ bad);
		bit_out(!(bad && !par_en()));
		if (fmt >= 3'h3)
			bit_out(1'b1);
		rxd <= 1'b1;
	endtask: send_char
	initial
	begin
		logic [7:0] b;
		logic e;
		forever
		begin
			@(negedge txd);
			repeat (div / 2) @(posedge ref_clk);
			e = txd;
			for (int i = 0; i < 8; i++)
			begin
				repeat (div) @(posedge ref_clk);
				b[i] = txd;
			end
			if (par_en())
			begin
				repeat (div) @(posedge ref_clk);
				e = e | (txd ^ par_of(b));
			end
			repeat (div) @(posedge ref_clk);
			mrx_err = e | !txd;
			mrx_b = b;
			mrx_n++;
		end
	end
endmodule: mrs_master_model

/* File: tb/mrs_serial_port_bench.sv */
// Self-checking bench of the serial slave port.
// Assumes the master model on the line and a shortened CLK_HZ.
`timescale 1ns/1ps
`include "mrs_cfg.svh"
module mrs_serial_port_bench;
	import mrs_pkg::*;
	typedef struct packed {
		logic [2:0] baud;
		logic [2:0] fmt;
		logic [7:0] b;
		logic bad;
		logic ok;
	} mrs_row_s;
	localparam int CLK = 576000;
	localparam int MS = CLK / 1000;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_we = 1'b0;
	logic reg_re = 1'b0;
	logic [31:0] reg_rdata;
	logic rxd, txd, txd_oe, rx_byte_valid, frame_valid, frame_bcast;
	mrs_byte_t rx_byte;
	mrs_byte_t tx_data = 8'h00;
	logic tx_valid = 1'b0;
	logic tx_last = 1'b0;
	logic tx_ready, comm_fault, irq;
	int fail_count = 0;
	int check_count = 0;
	int cyc = 0, rxv_n = 0, fv_n = 0, fb_n = 0, fv_t = 0, tr_t = 0;
	logic [7:0] rxv_b;
	int bauds [6] = '{`MRS_BAUD0, `MRS_BAUD1, `MRS_BAUD2, `MRS_BAUD3, `MRS_BAUD4, `MRS_BAUD5};
	logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h30};
	logic [31:0] rv [8] = '{32'h1, 32'h1, 32'h0, 32'h0, 32'h2, 32'h0, 32'h0, 32'h0};
	mrs_row_s rows [9] = '{'{3'h0, 3'h0, 8'hA5, 1'b0, 1'b1}, '{3'h1, 3'h1, 8'h5C, 1'b0, 1'b1},
		'{3'h2, 3'h2, 8'h80, 1'b0, 1'b1}, '{3'h3, 3'h3, 8'h3C, 1'b0, 1'b1},
		'{3'h4, 3'h4, 8'h7F, 1'b0, 1'b1}, '{3'h5, 3'h5, 8'hFE, 1'b0, 1'b1},
		'{3'h1, 3'h1, 8'h13, 1'b1, 1'b0}, '{3'h2, 3'h5, 8'h13, 1'b1, 1'b0},
		'{3'h1, 3'h3, 8'h13, 1'b1, 1'b0}};
	initial forever #2.5 ref_clk = ~ref_clk;
	mrs_serial_port #(.CLK_HZ(CLK)) i_mrs_serial_port (.ref_clk(ref_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
		.reg_rdata(reg_rdata), .rxd(rxd), .txd(txd), .txd_oe(txd_oe), .rx_byte(rx_byte),
		.rx_byte_valid(rx_byte_valid), .frame_valid(frame_valid), .frame_bcast(frame_bcast),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
		.comm_fault(comm_fault), .irq(irq));
	mrs_master_model i_mrs_master_model (.ref_clk(ref_clk), .rxd(rxd), .txd(txd));
	// ----------------------------------------
	// Event log
	// ----------------------------------------
	always @(posedge ref_clk)
	begin
		cyc++;
		if (rx_byte_valid === 1'b1)
		begin
			rxv_n++;
			rxv_b = rx_byte;
		end
		if (frame_valid === 1'b1)
		begin
			fv_n++;
			fv_t = cyc;
		end
		if (frame_bcast === 1'b1)
			fb_n++;
		if (tx_ready === 1'b1 && tr_t <= fv_t)
			tr_t = cyc;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask: check
	task automatic test_done();
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask: test_done
	task automatic give_up();
		fail_count++;
		$display("unexpected at %0t: wait ran out", $time);
		test_done();
	endtask: give_up
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask: idle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_we <= 1'b0;
		#1;
	endtask: wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_re <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask: rdc
	task automatic send_frame(input logic [7:0] a, input logic bad);
		logic [7:0] f [6];
		logic [15:0] c;
		f = '{a, 8'h03, 8'h00, 8'h01, 8'h00, 8'h00};
		c = `MRS_CRC_INIT;
		for (int i = 0; i < 4; i++)
		begin
			c = c ^ {8'h00, f[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ `MRS_CRC_POLY : c >> 1;
		end
		f[4] = c[7:0] ^ {7'h00, bad};
		f[5] = c[15:8];
		for (int i = 0; i < 6; i++)
			i_mrs_master_model.send_char(f[i], 1'b0);
		idle(40 * i_mrs_master_model.div);
	endtask: send_frame
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		int n, m, k;
		repeat (3) @(posedge ref_clk);
		check(32'({txd, txd_oe, tx_ready, comm_fault, irq}), 32'h10);
		rst <= 1'b0;
		foreach (ra[i])
			rdc(ra[i], rv[i]);
		wr(`MRS_A_STATION, 32'h0);
		wr(`MRS_A_STATION, 32'hF8);
		rdc(`MRS_A_STATION, 32'h1);
		wr(`MRS_A_STATION, 32'hF7);
		rdc(`MRS_A_STATION, 32'hF7);
		wr(`MRS_A_STATION, 32'h1);
		wr(`MRS_A_BAUD, 32'h6);
		wr(`MRS_A_FMT, 32'h6);
		wr(`MRS_A_DLY, 32'h0);
		wr(`MRS_A_DLY, 32'h15);
		rdc(`MRS_A_BAUD, 32'h1);
		rdc(`MRS_A_FMT, 32'h0);
		rdc(`MRS_A_DLY, 32'h2);
		foreach (rows[i])
		begin
			wr(`MRS_A_BAUD, 32'(rows[i].baud));
			wr(`MRS_A_FMT, 32'(rows[i].fmt));
			i_mrs_master_model.div = CLK / bauds[rows[i].baud];
			i_mrs_master_model.fmt = rows[i].fmt;
			n = rxv_n;
			i_mrs_master_model.send_char(rows[i].b, rows[i].bad);
			idle(40 * i_mrs_master_model.div);
			check(32'(rxv_n - n), 32'(rows[i].ok));
			if (rows[i].ok)
				check(32'(rxv_b), 32'(rows[i].b));
		end
		wr(`MRS_A_BAUD, 32'h5);
		wr(`MRS_A_FMT, 32'h0);
		i_mrs_master_model.div = CLK / `MRS_BAUD5;
		i_mrs_master_model.fmt = 3'h0;
		wr(`MRS_A_CLR, 32'h7);
		wr(`MRS_A_IEN, 32'h7);
		n = fv_n;
		send_frame(8'h01, 1'b0);
		check(32'(fv_n - n), 32'h1);
		rdc(`MRS_A_STAT, 32'h1);
		check(32'(irq), 32'h1);
		for (k = 0; k < 3 * MS && tx_ready !== 1'b1; k++)
			idle(1);
		if (tx_ready !== 1'b1)
			give_up();
		idle(1);
		check(32'(tr_t - fv_t), 32'(2 * MS));
		@(posedge ref_clk);
		tx_data <= 8'h5A;
		tx_valid <= 1'b1;
		tx_last <= 1'b1;
		@(posedge ref_clk);
		tx_valid <= 1'b0;
		tx_last <= 1'b0;
		m = i_mrs_master_model.mrx_n;
		idle(3);
		check(32'(txd_oe), 32'h1);
		idle(60);
		check(32'(txd_oe), 32'h0);
		check(32'(i_mrs_master_model.mrx_n - m), 32'h1);
		check(32'({i_mrs_master_model.mrx_err, i_mrs_master_model.mrx_b}), 32'h5A);
		wr(`MRS_A_CLR, 32'h7);
		check(32'(irq), 32'h0);
		n = fv_n;
		m = fb_n;
		send_frame(8'h02, 1'b0);
		check(32'(fv_n - n), 32'h0);
		send_frame(8'h00, 1'b0);
		check(32'({fv_n - n, fb_n - m}), 32'h00000001);
		check(32'(fv_n - n), 32'h1);
		idle(3 * MS);
		check(32'(tx_ready), 32'h0);
		wr(`MRS_A_CLR, 32'h7);
		send_frame(8'h01, 1'b1);
		check(32'(fv_n - n), 32'h1);
		rdc(`MRS_A_STAT, 32'h2);
		check(32'(irq), 32'h1);
		wr(`MRS_A_IEN, 32'h0);
		check(32'(irq), 32'h0);
		wr(`MRS_A_CLR, 32'h7);
		check(32'(comm_fault), 32'h0);
		wr(`MRS_A_TMO, 32'h1);
		wr(`MRS_A_IEN, 32'h4);
		send_frame(8'h01, 1'b0);
		idle(94 * MS);
		check(32'(comm_fault), 32'h0);
		for (k = 0; k < 12 * MS && comm_fault !== 1'b1; k++)
			idle(1);
		if (comm_fault !== 1'b1)
			give_up();
		check(32'(irq), 32'h1);
		rdc(`MRS_A_STAT, 32'h5);
		send_frame(8'h01, 1'b0);
		check(32'(comm_fault), 32'h0);
		test_done();
	end
	initial
	begin
		repeat (100000) @(posedge ref_clk);
		give_up();
	end
endmodule: mrs_serial_port_bench
